//--- core/ctu_defines.svh
`ifndef CTU_DEFINES_SVH
`define CTU_DEFINES_SVH
`define CTU_NUM_CH        4
`define CTU_BIT_CTRL      0
`define CTU_BIT_RESET     1
`define CTU_BIT_TC_NEXT   2
`define CTU_BIT_TRIG_EN   3
`define CTU_BIT_EDGE      4
`define CTU_BIT_PRE256    5
`define CTU_BIT_COUNTER   6
`define CTU_BIT_IRQ_EN    7
`define CTU_CTRL_RESET    8'h00
`define CTU_VEC_RESET     8'h00
`define CTU_PRE_SMALL     8'h0f
`define CTU_PRE_LARGE     8'hff
`define CTU_TRIG_DELAY    2'h2
`define CTU_VEC_CH_LSB    1
`endif

//--- core/ctu_pkg.sv
package ctu_pkg;
    typedef enum logic [1:0]
    {
        CTU_IDLE   = 2'b00,
        CTU_ARMED  = 2'b01,
        CTU_DELAY  = 2'b11,
        CTU_RUN    = 2'b10
    } ctu_state_t;
endpackage

//--- core/ctu_channel.sv
`timescale 1ns/1ps
`include "ctu_defines.svh"
module ctu_channel
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_ctrl,
    input  wire logic       wr_tc,
    input  wire logic [7:0] wr_data,
    input  wire logic       trig_in,
    output logic [7:0]      ctrl_q,
    output logic            tc_pending_q,
    output logic [7:0]      count_q,
    output logic            zero_pulse_q,
    output logic            irq_q,
    input  wire logic       irq_clear
);
    ctu_pkg::ctu_state_t state_q;
    ctu_pkg::ctu_state_t state_d;
    logic [7:0] tc_q;
    logic [7:0] pre_q;
    logic [1:0] dly_q;
    logic       trig_prev_q;
    logic       tc_loaded_q;
    wire        chan_reset  = wr_ctrl && wr_data[`CTU_BIT_RESET];
    wire        counter_md  = ctrl_q[`CTU_BIT_COUNTER];
    wire        rise_sel    = ctrl_q[`CTU_BIT_EDGE];
    // Edge selected by bit 4
    wire        trig_edge   = rise_sel ? (trig_in && !trig_prev_q)
                                       : (!trig_in && trig_prev_q); // [RL7]
    wire [7:0]  pre_top     = ctrl_q[`CTU_BIT_PRE256] ? `CTU_PRE_LARGE
                                                      : `CTU_PRE_SMALL; // [RL6]
    wire        running     = (state_q == ctu_pkg::CTU_RUN);
    wire        pre_tick    = running && !counter_md && (pre_q == 8'h00); // [RL5]
    wire        cnt_tick    = running && counter_md && trig_edge; // [RL4]
    wire        dec         = pre_tick || cnt_tick;
    wire        hit_zero    = dec && (count_q == 8'h01);
    // Zero-valued constant holds 256 in an 8-bit counter by wrapping
    wire [7:0]  count_dec   = count_q - 8'h01; // [RL15]

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ctu_pkg::CTU_IDLE:
                if (wr_tc && tc_loaded_q)
                    state_d = ctu_pkg::CTU_ARMED;
            ctu_pkg::CTU_ARMED:
                // Auto start or wait for trigger in timer mode
                if (counter_md || !ctrl_q[`CTU_BIT_TRIG_EN])
                    state_d = ctu_pkg::CTU_RUN; // [RL9] [RL14]
                else if (trig_edge)
                    state_d = ctu_pkg::CTU_DELAY; // [RL8]
            ctu_pkg::CTU_DELAY:
                if (dly_q == 2'h1)
                    state_d = ctu_pkg::CTU_RUN; // [RL8]
            ctu_pkg::CTU_RUN:
                state_d = ctu_pkg::CTU_RUN;
        endcase
        if (chan_reset)
            state_d = ctu_pkg::CTU_IDLE; // [RL12]
        else if (wr_tc && state_q == ctu_pkg::CTU_IDLE)
            state_d = ctu_pkg::CTU_ARMED; // [RL13] [RL14]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q      <= ctu_pkg::CTU_IDLE; // [RL26]
            ctrl_q       <= `CTU_CTRL_RESET;
            tc_pending_q <= 1'b0;
            tc_q         <= 8'h00;
            tc_loaded_q  <= 1'b0;
            count_q      <= 8'h00;
            pre_q        <= 8'h00;
            dly_q        <= 2'h0;
            trig_prev_q  <= 1'b0;
            zero_pulse_q <= 1'b0;
            irq_q        <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            trig_prev_q <= trig_in;
            if (wr_ctrl)
            begin
                // Reset bit is a pulse, never stored
                ctrl_q       <= {wr_data[7:2], 1'b0, 1'b1}; // [RL2] [RL12]
                tc_pending_q <= wr_data[`CTU_BIT_TC_NEXT]; // [RL10]
            end
            else if (wr_tc)
                tc_pending_q <= 1'b0;
            if (wr_tc)
            begin
                tc_q        <= wr_data; // [RL10]
                tc_loaded_q <= 1'b1;
            end
            if (state_d == ctu_pkg::CTU_DELAY && state_q != ctu_pkg::CTU_DELAY)
                dly_q <= `CTU_TRIG_DELAY;
            else if (dly_q != 2'h0)
                dly_q <= dly_q - 2'h1;
            if (state_q != ctu_pkg::CTU_RUN)
            begin
                count_q <= wr_tc ? wr_data : tc_q;
                pre_q   <= pre_top;
            end
            else
            begin
                if (!counter_md)
                    pre_q <= (pre_q == 8'h00) ? pre_top : pre_q - 8'h01;
                if (hit_zero)
                    count_q <= tc_q; // [RL16] [RL23]
                else if (dec)
                    count_q <= count_dec;
            end
            zero_pulse_q <= hit_zero && !chan_reset; // [RL24]
            // New zero counts set; older ones are not retroactive
            if (hit_zero && ctrl_q[`CTU_BIT_IRQ_EN])
                irq_q <= 1'b1; // [RL3]
            else if (irq_clear || (wr_ctrl && !wr_data[`CTU_BIT_IRQ_EN]))
                irq_q <= 1'b0;
        end
    end
endmodule

//--- core/ctu_top.sv
`timescale 1ns/1ps
`include "ctu_defines.svh"
// How it works
// RL1 - Two select inputs form binary channel index for writes and reads.
// RL2 - Word with bit 0 set becomes the channel control word.
// RL3 - Bit 7 enables interrupt on each zero count, never retroactively.
// RL4 - Counter mode: selected trigger edge decrements counter, no prescaler.
// RL5 - Timer mode: system clock through prescaler decrements counter.
// RL6 - Bit 5 picks prescale 256 when set, 16 when clear.
// RL7 - Bit 4 picks rising or falling trigger edge.
// RL8 - Bit 3 set: trigger accepted after load, counting starts two clocks later.
// RL9 - Bit 3 clear: timer starts automatically after constant load.
// RL10 - Bit 2 set: next word to channel is the time constant.
// RL11 - Software clears bit 2 only when a valid constant exists.
// RL12 - Bit 1 pulses channel reset; not stored, other bits kept.
// RL13 - Reset with bit 2 set restarts once the constant arrives.
// RL14 - No counting until a time constant follows a bit-2 control word.
// RL15 - Constant zero means 256.
// RL16 - New constant waits until current count reaches zero.
// RL17 - Channel 0 word with bit 0 clear stores upper five vector bits.
// RL18 - Vector bits 1 and 2 carry the interrupting channel code.
// RL19 - Write cycle: read high, request and enable low, machine-cycle-one high.
// RL20 - Written word latched on edge starting third state.
// RL21 - Read returns counter sampled at second-state edge by third state.
// RL22 - Host inserts no wait states in these cycles.
// RL23 - Counter reloads from constant at zero and keeps going.
// RL24 - Channels 0 to 2 pulse zero-count output; channel 3 none.
// RL25 - Lowest numbered requesting channel has interrupt priority.
// RL26 - Reset stops channels, clears enables, outputs inactive.
// RL27 - Channel code in vector bits 2 to 1 equals channel number.
module ctu_top
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       chip_enable_n,
    input  wire logic       io_request_n,
    input  wire logic       read_n,
    input  wire logic       machine_cycle_one_n,
    input  wire logic       channel_select_low,
    input  wire logic       channel_select_high,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe_n,
    input  wire logic [3:0] external_clock_trigger,
    output logic [2:0]      zero_count_pulse,
    output logic            interrupt_n,
    output logic [7:0]      vector_out,
    output logic [3:0]      irq_pending,
    output logic [3:0]      irq_enable,
    input  wire logic [3:0] irq_clear
);
    localparam int NCH = `CTU_NUM_CH;
    logic [7:0] vec_base_q;
    logic [7:0] rd_data_q;
    logic       rd_oe_q;
    logic       cyc_q;
    logic [7:0] ctrl_w [NCH];
    logic [7:0] cnt_w [NCH];
    logic [NCH-1:0] pend_w;
    logic [NCH-1:0] irq_w;
    logic [NCH-1:0] zp_w;
    wire [1:0]  sel     = {channel_select_high, channel_select_low}; // [RL1]
    wire        access  = !chip_enable_n && !io_request_n && machine_cycle_one_n;
    // One strobe per bus cycle, taken on the edge after request goes low
    wire        start   = access && !cyc_q;
    wire        wr_stb  = start && read_n; // [RL19] [RL20] [RL22]
    wire        rd_stb  = start && !read_n; // [RL21]
    wire [NCH-1:0] sel_dec = 4'h1 << sel;
    wire        sel_tc  = pend_w[sel];
    wire        is_ctrl = data_in[`CTU_BIT_CTRL] && !sel_tc;
    wire        wr_vec  = wr_stb && !sel_tc && !data_in[`CTU_BIT_CTRL] && (sel == 2'h0);

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            ctu_channel u_ch
            (
                .clk          (clk),
                .rst_n        (rst_n),
                .wr_ctrl      (wr_stb && sel_dec[g] && is_ctrl), // [RL2]
                .wr_tc        (wr_stb && sel_dec[g] && pend_w[g]), // [RL10]
                .wr_data      (data_in),
                .trig_in      (external_clock_trigger[g]),
                .ctrl_q       (ctrl_w[g]),
                .tc_pending_q (pend_w[g]),
                .count_q      (cnt_w[g]),
                .zero_pulse_q (zp_w[g]),
                .irq_q        (irq_w[g]),
                .irq_clear    (irq_clear[g])
            );
            assign irq_enable[g] = ctrl_w[g][`CTU_BIT_IRQ_EN];
        end
    endgenerate

    // Channel 3 zero pulse is internal only
    assign zero_count_pulse = zp_w[2:0]; // [RL24]
    assign irq_pending      = irq_w;
    assign interrupt_n      = !(|irq_w);
    wire [1:0] win = irq_w[0] ? 2'h0 :
                     irq_w[1] ? 2'h1 :
                     irq_w[2] ? 2'h2 : 2'h3; // [RL25]
    assign vector_out = {vec_base_q[7:3], win, 1'b0}; // [RL18] [RL27]
    assign data_out   = rd_data_q;
    assign data_oe_n  = !rd_oe_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vec_base_q <= `CTU_VEC_RESET;
            rd_data_q  <= 8'h00;
            rd_oe_q    <= 1'b0;
            cyc_q      <= 1'b0;
        end
        else
        begin
            cyc_q <= access;
            if (wr_vec)
                vec_base_q <= {data_in[7:3], 3'h0}; // [RL17]
            if (rd_stb)
                rd_data_q <= cnt_w[sel]; // [RL21]
            rd_oe_q <= access && !read_n;
        end
    end
endmodule

//--- tb/ctu_top_assertions.sv
`timescale 1ns/1ps
module ctu_top_chk
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       chip_enable_n,
    input wire logic       io_request_n,
    input wire logic       read_n,
    input wire logic       machine_cycle_one_n,
    input wire logic [7:0] data_out,
    input wire logic       data_oe_n,
    input wire logic [2:0] zero_count_pulse,
    input wire logic       interrupt_n,
    input wire logic [7:0] vector_out,
    input wire logic [3:0] irq_pending,
    input wire logic [3:0] irq_enable
);
    wire logic acc = !chip_enable_n && !io_request_n && machine_cycle_one_n;
    wire logic rd  = acc && !read_n;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_rd_start;
        !rd ##1 rd;
    endsequence
    sequence s_quiet;
        !rd [*3];
    endsequence
    AST_INT_LEVEL: assert property (interrupt_n == !(|irq_pending))
        else $error("int level");
    AST_VEC_CH0: assert property (irq_pending[0] |-> vector_out[2:0] == 3'h0)
        else $error("vec ch0");
    AST_VEC_CH1: assert property (irq_pending[1:0] == 2'h2 |-> vector_out[2:0] == 3'h2)
        else $error("vec ch1");
    AST_ZC_ONE: assert property (zero_count_pulse[0] |=> !zero_count_pulse[0])
        else $error("zc width");
    AST_IRQ_EN: assert property ($rose(irq_pending[1]) |-> irq_enable[1])
        else $error("irq no enable");
    AST_OE_READ: assert property (s_rd_start |=> !data_oe_n)
        else $error("oe read");
    AST_OE_IDLE: assert property (s_quiet |-> data_oe_n)
        else $error("oe idle");
    AST_DOUT_HOLD: assert property (s_quiet |-> $stable(data_out))
        else $error("dout hold");
    AST_EN_HOLD: assert property (!acc [*2] |-> $stable(irq_enable))
        else $error("enable hold");
endmodule
bind ctu_top ctu_top_chk u_chk (.*);

//--- tb/ctu_host.sv
`timescale 1ns/1ps
module ctu_host
(
    input wire logic       clk,
    output logic           chip_enable_n,
    output logic           io_request_n,
    output logic           read_n,
    output logic           machine_cycle_one_n,
    output logic           channel_select_low,
    output logic           channel_select_high,
    output logic [7:0]     data_in,
    input wire logic [7:0] data_out
);
    initial
    begin
        {chip_enable_n, io_request_n, read_n, machine_cycle_one_n} = 4'hf;
        {channel_select_high, channel_select_low} = 2'h0;
        data_in = 8'h00;
    end
    // Read data taken at the second falling edge after the take edge, then released
    task automatic cyc(input logic [1:0] ch, input int rd, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk);
        {channel_select_high, channel_select_low} = ch;
        data_in = rd ? ~data_in : d;
        read_n = !rd;
        {chip_enable_n, io_request_n} = 2'h0;
        @(negedge clk);
        if (rd)
            @(negedge clk);
        q = data_out;
        {chip_enable_n, io_request_n, read_n} = 3'h7;
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_n, chip_enable_n, io_request_n, read_n, data_oe_n, interrupt_n;
    logic        machine_cycle_one_n, channel_select_low, channel_select_high;
    logic [7:0]  data_in, data_out, vector_out, tc, cw, q;
    logic [3:0]  external_clock_trigger, irq_pending, irq_enable, irq_clear;
    logic [2:0]  zero_count_pulse;
    logic [31:0] seed;
    int          errors, n_tests, p;
    int          zc[3];
    logic [7:0]  cw_list[2] = '{8'h07, 8'h27};
    ctu_top dut (.*);
    ctu_host host (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic int per(input logic [7:0] c, input logic [7:0] t);
        return (c[5] ? 256 : 16) * (t == 8'h00 ? 256 : int'(t));
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %s exp %0h got %0h", nm, e, s);
        end
    endtask
    task automatic pulse(input int ch, input int n);
        repeat (2 * n)
        begin
            repeat (2) @(negedge clk);
            external_clock_trigger[ch] = ~external_clock_trigger[ch];
        end
    endtask
    task automatic zwait(output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (zero_count_pulse[0] !== 1'b1 && n < 3000);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
        for (int i = 0; i < 3; i++)
            if (zero_count_pulse[i] === 1'b1)
                zc[i]++;
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #300000;
        errors++;
        give_verdict();
    end
    initial
    begin
        rst_n = 0;
        external_clock_trigger = 4'h0;
        irq_clear = 4'h0;
        seed = 32'h4060;
        repeat (8) @(posedge clk);
        @(negedge clk) rst_n = 1;
        chk("int_n", 1, interrupt_n);
        chk("irq_en", 0, irq_enable);
        chk("zc", 0, zero_count_pulse);
        host.cyc(2'h0, 0, 8'ha6, q);
        for (int ch = 0; ch < 4; ch++)
        begin
            seed = xs(seed);
            tc = (ch == 3) ? 8'h00 : {5'h0, seed[2:0]} + 8'h02;
            external_clock_trigger[ch] = !ch[0];
            cw = {ch[0], 1'b1, 1'b0, ch[0], 4'h7};
            host.cyc(ch[1:0], 0, cw, q);
            host.cyc(ch[1:0], 0, tc, q);
            pulse(ch, 1);
            host.cyc(ch[1:0], 1, 8'h00, q);
            chk("count", 8'(tc - 8'h01), q);
            pulse(ch, (tc == 8'h00 ? 256 : int'(tc)) - 1);
            repeat (3) @(negedge clk);
            host.cyc(ch[1:0], 1, 8'h00, q);
            chk("reload", tc, q);
            if (ch < 3)
                chk("zc_cnt", 1, zc[ch]);
            chk("pend", ch[0], irq_pending[ch]);
            chk("int_n_act", !ch[0], interrupt_n);
            if (ch[0])
                chk("vector", {5'h14, ch[1:0], 1'b0}, vector_out);
            irq_clear[ch] = 1'b1;
            @(negedge clk) irq_clear[ch] = 1'b0;
        end
        $display("counter mode done");
        // Reset bit halts the channel while the rest of the word is stored
        host.cyc(2'h1, 0, 8'hd3, q);
        chk("en_kept", 4'ha, irq_enable);
        // Machine cycle one active marks an acknowledge, never a register write
        host.machine_cycle_one_n = 1'b0;
        host.cyc(2'h1, 0, 8'h03, q);
        host.machine_cycle_one_n = 1'b1;
        chk("m1_refused", 4'ha, irq_enable);
        pulse(1, 12);
        chk("halted", 0, irq_pending[1]);
        $display("channel reset done");
        tc = 8'h02;
        foreach (cw_list[i])
        begin
            cw = cw_list[i];
            host.cyc(2'h0, 0, cw, q);
            host.cyc(2'h0, 0, tc, q);
            zwait(p);
            zwait(p);
            chk("period", per(cw, tc), p);
        end
        // Park the trigger low so the later rise is a real edge
        external_clock_trigger[0] = 1'b0;
        host.cyc(2'h0, 0, 8'h1f, q);
        host.cyc(2'h0, 0, 8'h01, q);
        p = zc[0];
        repeat (40) @(negedge clk);
        chk("no_start", p, zc[0]);
        external_clock_trigger[0] = 1'b1;
        zwait(p);
        chk("trig_start", 1, p >= 17 && p <= 20);
        $display("timer mode done");
        give_verdict();
    end
endmodule
